//--- src/amc_pkg.sv
// Behaviour
// - test pattern enabled drives the fixed pattern on all data bits of both channels
// - driver disable turns off every output including data clock and frame
// - sleep powers down everything; set by register or by SDI strap
// - nap powers down selected channels only; at least 100 sample clocks to recover
// - program select high makes the four port pins static mode straps
// - parallel mode: CS/SCK pair 00 two lanes, 01 four, 10 one lane
// - parallel mode: SDI strap low normal, high sleep
// - parallel mode: SDO strap low 3.5 mA, high 1.75 mA
// - program select low makes a serial port; one 16-bit word per access
// - frame is chip select low; SDI taken on first 16 SCK rises only
// - word is read/write flag, seven address bits, eight data bits, MSB first
// - flag low writes data into addressed register
// - flag high reads register on SDO, no update, SDI data ignored
// - SDO only pulls low, released for a one
// - reset bit D7 clears all registers and briefly sleeps; bit self-clears
// - reset register is write-only; reads are arbitrary; low bits ignored
// - format bit 6 enables the randomizer
// - bits 4,3,0 select sleep, channel two nap, channel one nap
// - output register: lanes 1-0, pattern 2, disable 3, termination 4, current 7-5
// - pattern high byte at 03h, low byte at 04h
package amc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [6:0] AMC_ADDR_RESET    = 7'h00;
    localparam logic [6:0] AMC_ADDR_FORMAT   = 7'h01;
    localparam logic [6:0] AMC_ADDR_OUTMODE  = 7'h02;
    localparam logic [6:0] AMC_ADDR_PAT_HIGH = 7'h03;
    localparam logic [6:0] AMC_ADDR_PAT_LOW  = 7'h04;
    localparam logic [7:0] AMC_REG_RESET_VAL = 8'h00;
    localparam logic [7:0] AMC_RESET_READ    = 8'h00;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AMC_RST_BIT    = 7;
    localparam int AMC_FMT_DCS    = 7;
    localparam int AMC_FMT_SCRAMBLE_ENABLE   = 6;
    localparam int AMC_FMT_TWOS   = 5;
    localparam int AMC_FMT_SLEEP  = 4;
    localparam int AMC_FMT_NAP2   = 3;
    localparam int AMC_FMT_NAP1   = 0;
    localparam int AMC_OM_LANE_LO = 0;
    localparam int AMC_OM_PATTERN = 2;
    localparam int AMC_OM_DISABLE = 3;
    localparam int AMC_OM_TERM    = 4;
    localparam int AMC_OM_CUR_LO  = 5;
    // ************************************************************
    // strap encodings and serial framing
    // ************************************************************
    localparam logic [1:0] AMC_LANES_TWO  = 2'h0;
    localparam logic [1:0] AMC_LANES_FOUR = 2'h1;
    localparam logic [1:0] AMC_LANES_ONE  = 2'h2;
    localparam logic [2:0] AMC_CUR_3P5MA  = 3'h0;
    localparam logic [2:0] AMC_CUR_1P75MA = 3'h4;
    localparam logic [4:0] AMC_WORD_BITS  = 5'h10;
    localparam logic [4:0] AMC_HDR_BITS   = 5'h08;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int AMC_CLK_NS          = 25;
    localparam int AMC_NAP_WAKE_CYCLES = 100;
    localparam int AMC_SLEEP_PULSE_NS  = 100;
    localparam int AMC_SLEEP_PULSE_CYC = (AMC_SLEEP_PULSE_NS + AMC_CLK_NS - 1) / AMC_CLK_NS;
endpackage

//--- src/amc_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for the pins
module amc_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk_i, // system clock
    input  wire logic         reset_i,   // sync reset
    input  wire logic [W-1:0] async_i,   // raw pins
    output logic      [W-1:0] sync_o     // synchronised
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // first stage feeds only the second
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule // amc_sync

//--- src/amc_config_port.sv
`timescale 1ns/1ps
module amc_config_port
    import amc_pkg::*;
(
    input  wire logic        sys_clk_i,        // 40 MHz clock
    input  wire logic        reset_i,          // sync reset, active high
    input  wire logic        program_select_i, // 1 straps, 0 serial
    input  wire logic        cs_n_i,           // chip select / lane strap
    input  wire logic        sck_i,            // serial clock / lane strap
    input  wire logic        sdi_i,            // serial data in / sleep strap
    input  wire logic        sdo_i,            // sdo pin level / current strap
    input  wire logic        sample_tick_i,    // one pulse per sample clock
    input  wire logic [15:0] ch1_data_i,       // channel one raw offset binary
    input  wire logic [15:0] ch2_data_i,       // channel two raw offset binary
    output logic             sdo_o,            // sdo drive value (always 0)
    output logic             sdo_oe_o,         // sdo pull-down enable
    output logic [15:0]      ch1_data_o,       // channel one formatted data
    output logic [15:0]      ch2_data_o,       // channel two formatted data
    output logic             driver_disable_o, // all outputs incl clock, frame off
    output logic [1:0]       lane_count_select_o,       // lane mode
    output logic [2:0]       driver_current_select_o,   // lvds current code
    output logic             internal_termination_on_o, // termination on
    output logic             duty_stabilizer_off_o,     // stabilizer off
    output logic             sleep_o,          // whole device down
    output logic             ch1_nap_o,        // channel one napping
    output logic             ch2_nap_o,        // channel two napping
    output logic             ch1_ready_o,      // channel one awake and settled
    output logic             ch2_ready_o       // channel two awake and settled
);
    import amc_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [4:0] pin_s;
    amc_sync #(.W(5)) u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .async_i   ({program_select_i, cs_n_i, sck_i, sdi_i, sdo_i}),
        .sync_o    (pin_s)
    );
    logic ps_s, cs_s, sck_s, sdi_s, sdo_s;
    assign {ps_s, cs_s, sck_s, sdi_s, sdo_s} = pin_s;

    function automatic logic [15:0] fmt_word(input logic [15:0] raw, input logic twos,
                                            input logic rnd);
        logic [15:0] w;
        w = raw;
        if (twos) w[15] = ~w[15];
        if (rnd) w[15:1] = w[15:1] ^ {15{w[0]}};
        return w;
    endfunction

    function automatic logic [6:0] wake_load(input logic napped, input logic [6:0] cnt);
        if (napped) return 7'(AMC_NAP_WAKE_CYCLES);
        return cnt;
    endfunction

    // ************************************************************
    // serial port state
    // ************************************************************
    logic        sck_d_reg, sck_d_next;
    logic [4:0]  cnt_reg, cnt_next;
    logic [15:0] shift_reg, shift_next;
    logic [7:0]  rd_reg, rd_next;
    logic        oe_reg, oe_next;
    logic [7:0]  fmt_reg, fmt_next;
    logic [7:0]  om_reg, om_next;
    logic [7:0]  pat_hi_reg, pat_hi_next;
    logic [7:0]  pat_lo_reg, pat_lo_next;
    logic [2:0]  srst_reg, srst_next;
    logic        serial;
    logic        rise, fall;
    logic [15:0] word;
    logic [7:0]  rd_val;
    logic [6:0]  rd_addr;
    logic        rd_act_reg, rd_act_next;

    // program select low turns the straps into the serial port
    assign serial = ~ps_s;
    assign rise   = sck_s & ~sck_d_reg;
    assign fall   = ~sck_s & sck_d_reg;
    // the address is only complete with the bit arriving on the eighth rise
    assign rd_addr = {shift_reg[5:0], sdi_s};

    // register read mux; the reset register reads as an arbitrary constant
    always_comb begin
        rd_val = 8'h00;
        if (rd_addr == AMC_ADDR_RESET) begin
            rd_val = AMC_RESET_READ;
        end else if (rd_addr == AMC_ADDR_FORMAT) begin
            rd_val = fmt_reg;
        end else if (rd_addr == AMC_ADDR_OUTMODE) begin
            rd_val = om_reg;
        end else if (rd_addr == AMC_ADDR_PAT_HIGH) begin
            rd_val = pat_hi_reg;
        end else if (rd_addr == AMC_ADDR_PAT_LOW) begin
            rd_val = pat_lo_reg;
        end
    end

    // frame, bit counter, shifter and register writes
    always_comb begin
        sck_d_next  = sck_s;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        rd_next     = rd_reg;
        oe_next     = oe_reg;
        rd_act_next = rd_act_reg;
        fmt_next    = fmt_reg;
        om_next     = om_reg;
        pat_hi_next = pat_hi_reg;
        pat_lo_next = pat_lo_reg;
        srst_next   = (srst_reg != 3'h0) ? srst_reg - 3'h1 : 3'h0;
        word        = {shift_reg[14:0], sdi_s};
        if (!serial || cs_s) begin
            // straps: port idle, sdo never driven
            cnt_next = 5'h00;
            oe_next  = 1'b0;
            rd_act_next = 1'b0;
        end else begin
            // only the first 16 rises are taken
            if (rise && cnt_reg < AMC_WORD_BITS) begin
                cnt_next   = cnt_reg + 5'h01;
                shift_next = word;
                if (cnt_reg == AMC_HDR_BITS - 5'h01) begin
                    // flag picks a read; sdi data of a read is never written
                    rd_act_next = word[7];
                    rd_next     = rd_val;
                end
                if (cnt_reg == AMC_WORD_BITS - 5'h01 && !shift_reg[14]) begin
                    if (word[14:8] == AMC_ADDR_RESET) begin
                        if (word[AMC_RST_BIT]) begin
                            fmt_next    = AMC_REG_RESET_VAL;
                            om_next     = AMC_REG_RESET_VAL;
                            pat_hi_next = AMC_REG_RESET_VAL;
                            pat_lo_next = AMC_REG_RESET_VAL;
                            srst_next   = 3'(AMC_SLEEP_PULSE_CYC);
                        end
                    end else if (word[14:8] == AMC_ADDR_FORMAT) begin
                        fmt_next = word[7:0];
                    end else if (word[14:8] == AMC_ADDR_OUTMODE) begin
                        om_next = word[7:0];
                    end else if (word[14:8] == AMC_ADDR_PAT_HIGH) begin
                        pat_hi_next = word[7:0];
                    end else if (word[14:8] == AMC_ADDR_PAT_LOW) begin
                        pat_lo_next = word[7:0];
                    end
                end
            end
            // read bits change on falling sck, msb first
            if (fall && rd_act_reg && cnt_reg >= AMC_HDR_BITS && cnt_reg < AMC_WORD_BITS) begin
                // open drain: enable only for a zero
                oe_next = ~rd_reg[7];
                rd_next = {rd_reg[6:0], 1'b0};
            end
            if (cnt_reg >= AMC_WORD_BITS && fall) begin
                oe_next = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sck_d_reg  <= 1'b0;
            cnt_reg    <= 5'h00;
            shift_reg  <= 16'h0000;
            rd_reg     <= 8'h00;
            oe_reg     <= 1'b0;
            rd_act_reg <= 1'b0;
            fmt_reg    <= AMC_REG_RESET_VAL;
            om_reg     <= AMC_REG_RESET_VAL;
            pat_hi_reg <= AMC_REG_RESET_VAL;
            pat_lo_reg <= AMC_REG_RESET_VAL;
            srst_reg   <= 3'h0;
        end else begin
            sck_d_reg  <= sck_d_next;
            cnt_reg    <= cnt_next;
            shift_reg  <= shift_next;
            rd_reg     <= rd_next;
            oe_reg     <= oe_next;
            rd_act_reg <= rd_act_next;
            fmt_reg    <= fmt_next;
            om_reg     <= om_next;
            pat_hi_reg <= pat_hi_next;
            pat_lo_reg <= pat_lo_next;
            srst_reg   <= srst_next;
        end
    end

    // ************************************************************
    // mode outputs and data formatting
    // ************************************************************
    logic        sleep_next, nap1_next, nap2_next, dis_next, term_next, dcs_next;
    logic [1:0]  lane_next;
    logic [2:0]  cur_next;
    logic [15:0] d1_next, d2_next;
    logic        sleep_reg, nap1_reg, nap2_reg, dis_reg, term_reg, dcs_reg;
    logic [1:0]  lane_reg;
    logic [2:0]  cur_reg;
    logic [15:0] d1_reg, d2_reg;
    logic [6:0]  wake1_reg, wake1_next, wake2_reg, wake2_next;
    logic        rdy1_reg, rdy1_next, rdy2_reg, rdy2_next;

    // mode decode from straps or registers
    always_comb begin
        if (serial) begin
            sleep_next = fmt_reg[AMC_FMT_SLEEP] | (srst_reg != 3'h0);
            nap1_next  = fmt_reg[AMC_FMT_NAP1] | sleep_next;
            nap2_next  = fmt_reg[AMC_FMT_NAP2] | sleep_next;
            lane_next  = om_reg[AMC_OM_LANE_LO +: 2];
            dis_next   = om_reg[AMC_OM_DISABLE];
            term_next  = om_reg[AMC_OM_TERM];
            cur_next   = om_reg[AMC_OM_CUR_LO +: 3];
            dcs_next   = fmt_reg[AMC_FMT_DCS];
        end else begin
            sleep_next = sdi_s;
            nap1_next  = sdi_s;
            nap2_next  = sdi_s;
            lane_next  = {cs_s, sck_s};
            dis_next   = 1'b0;
            term_next  = 1'b0;
            cur_next   = sdo_s ? AMC_CUR_1P75MA : AMC_CUR_3P5MA;
            dcs_next   = 1'b0;
        end
        wake1_next = wake_load(nap1_reg, (sample_tick_i && wake1_reg != 7'h00) ?
                               wake1_reg - 7'h01 : wake1_reg);
        wake2_next = wake_load(nap2_reg, (sample_tick_i && wake2_reg != 7'h00) ?
                               wake2_reg - 7'h01 : wake2_reg);
        // ready taken from the next values so it can never overlap a nap
        rdy1_next  = ~nap1_next & (wake1_next == 7'h00);
        rdy2_next  = ~nap2_next & (wake2_next == 7'h00);
        if (serial && om_reg[AMC_OM_PATTERN]) begin
            // high byte register on top, low byte register below
            d1_next = {pat_hi_reg, pat_lo_reg};
            d2_next = {pat_hi_reg, pat_lo_reg};
        end else begin
            // randomizer and two's complement, only in serial mode
            d1_next = fmt_word(ch1_data_i, serial & fmt_reg[AMC_FMT_TWOS],
                               serial & fmt_reg[AMC_FMT_SCRAMBLE_ENABLE]);
            d2_next = fmt_word(ch2_data_i, serial & fmt_reg[AMC_FMT_TWOS],
                               serial & fmt_reg[AMC_FMT_SCRAMBLE_ENABLE]);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sleep_reg <= 1'b0;
            nap1_reg  <= 1'b0;
            nap2_reg  <= 1'b0;
            dis_reg   <= 1'b0;
            term_reg  <= 1'b0;
            dcs_reg   <= 1'b0;
            lane_reg  <= AMC_LANES_TWO;
            cur_reg   <= AMC_CUR_3P5MA;
            d1_reg    <= 16'h0000;
            d2_reg    <= 16'h0000;
            wake1_reg <= 7'h00;
            wake2_reg <= 7'h00;
            rdy1_reg  <= 1'b0;
            rdy2_reg  <= 1'b0;
        end else begin
            sleep_reg <= sleep_next;
            nap1_reg  <= nap1_next;
            nap2_reg  <= nap2_next;
            dis_reg   <= dis_next;
            term_reg  <= term_next;
            dcs_reg   <= dcs_next;
            lane_reg  <= lane_next;
            cur_reg   <= cur_next;
            d1_reg    <= d1_next;
            d2_reg    <= d2_next;
            wake1_reg <= wake1_next;
            wake2_reg <= wake2_next;
            rdy1_reg  <= rdy1_next;
            rdy2_reg  <= rdy2_next;
        end
    end

    assign sdo_o                     = 1'b0;
    assign sdo_oe_o                  = oe_reg;
    assign ch1_data_o                = d1_reg;
    assign ch2_data_o                = d2_reg;
    // single disable covers data, clock and frame drivers
    assign driver_disable_o          = dis_reg;
    assign lane_count_select_o       = lane_reg;
    assign driver_current_select_o   = cur_reg;
    assign internal_termination_on_o = term_reg;
    assign duty_stabilizer_off_o     = dcs_reg;
    assign sleep_o                   = sleep_reg;
    assign ch1_nap_o                 = nap1_reg;
    assign ch2_nap_o                 = nap2_reg;
    assign ch1_ready_o               = rdy1_reg;
    assign ch2_ready_o               = rdy2_reg;
endmodule // amc_config_port

//--- verif/amc_host.sv
`timescale 1ns/1ps
// host side of the config pins: straps or serial frames
module amc_host (
    input  wire logic sys_clk_i,  // bench clock, paces the link
    input  wire logic sdo_line_i, // sdo wire after the pull-up
    output logic      cs_n_o,     // chip select / lane strap
    output logic      sck_o,      // serial clock / lane strap
    output logic      sdi_o       // serial data / sleep strap
);
    // link idles selected-off with sck still; it only toggles inside a frame
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    task automatic strap(input logic [2:0] v);
        {cs_n_o, sck_o, sdi_o} = v;
    endtask
    // one word per frame, flag, address, data, msb first
    task automatic xfer(input logic [15:0] word, input int rises, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_o = 1'b0;
        for (int i = 0; i < rises; i++) begin
            sdi_o = (i < 16) ? word[15-i] : 1'($urandom);
            repeat (4) @(negedge sys_clk_i);
            // read bits settle during the low half, taken just before the rise
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line_i};
            sck_o = 1'b1;
            repeat (4) @(negedge sys_clk_i);
            sck_o = 1'b0;
        end
        repeat (4) @(negedge sys_clk_i);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line must not keep the last bit
        repeat (6) @(negedge sys_clk_i);
    endtask
endmodule // amc_host

//--- verif/amc_config_port_props.sv
`timescale 1ns/1ps
// pin-level checks on the mode port
module amc_config_port_props (
    input wire logic       sys_clk_i,               // clock
    input wire logic       reset_i,                 // sync reset
    input wire logic       program_select_i,        // strap or serial
    input wire logic       cs_n_i,                  // chip select
    input wire logic       sck_i,                   // serial clock
    input wire logic       sdi_i,                   // serial data
    input wire logic       sdo_i,                   // sdo wire
    input wire logic       sdo_o,                   // sdo drive value
    input wire logic       sdo_oe_o,                // sdo pull-down
    input wire logic [1:0] lane_count_select_o,     // lanes
    input wire logic [2:0] driver_current_select_o, // current code
    input wire logic       duty_stabilizer_off_o,   // stabilizer off
    input wire logic       sleep_o,                 // sleep
    input wire logic       ch1_nap_o,               // nap one
    input wire logic       ch2_nap_o,               // nap two
    input wire logic       ch1_ready_o,             // ready one
    input wire logic       ch2_ready_o              // ready two
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // six settled cycles cover the two-stage synchroniser plus the output flop
    a_strap_lanes: assert property ((program_select_i && $stable({cs_n_i, sck_i}))[*6]
        |-> lane_count_select_o == {cs_n_i, sck_i}) else $error("lane strap not followed");
    a_strap_sleep: assert property ((program_select_i && $stable(sdi_i))[*6]
        |-> sleep_o == sdi_i) else $error("sleep strap not followed");
    a_strap_current: assert property ((program_select_i && $stable(sdo_i))[*6]
        |-> driver_current_select_o == (sdo_i ? 3'h4 : 3'h0)) else $error("current strap");
    a_strap_dcs: assert property (program_select_i[*6] |-> !duty_stabilizer_off_o)
        else $error("stabilizer off in strap mode");
    a_sdo_low_only: assert property (sdo_o == 1'b0) else $error("sdo driven high");
    a_sdo_released: assert property (cs_n_i[*6] |-> !sdo_oe_o)
        else $error("sdo pulled outside frame");
    // short reset pulse is excluded by asking for a held sleep
    a_sleep_naps: assert property (sleep_o[*5] |-> ch1_nap_o && ch2_nap_o)
        else $error("sleep without both channels down");
    a_nap_not_ready: assert property (!(ch1_nap_o && ch1_ready_o) &&
        !(ch2_nap_o && ch2_ready_o)) else $error("napped channel reports ready");
    a_wake_slow: assert property ($fell(ch1_nap_o) |-> (!ch1_ready_o)[*8])
        else $error("channel ready too soon after nap");
    a_wake_bound: assert property ($fell(ch1_nap_o) |-> ##[1:400] ch1_ready_o)
        else $error("channel never woke");
endmodule // amc_config_port_props
bind amc_config_port amc_config_port_props u_props (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .program_select_i(program_select_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .sdi_i(sdi_i), .sdo_i(sdo_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .lane_count_select_o(lane_count_select_o),
    .driver_current_select_o(driver_current_select_o),
    .duty_stabilizer_off_o(duty_stabilizer_off_o), .sleep_o(sleep_o),
    .ch1_nap_o(ch1_nap_o), .ch2_nap_o(ch2_nap_o), .ch1_ready_o(ch1_ready_o),
    .ch2_ready_o(ch2_ready_o));

//--- verif/tb_amc_config_port.sv
`timescale 1ns/1ps
module tb_amc_config_port;
    import amc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, ps = 1'b1, tick = 1'b0, sdo_strap = 1'b0;
    logic [15:0] d1 = 16'h0, d2 = 16'h0, q1, q2;
    logic        cs_n, sck, sdi, sdo_d, sdo_oe, dis, term, dcs, slp, nap1, nap2, rdy1, rdy2;
    logic [1:0]  lane;
    logic [2:0]  cur;
    logic [31:0] exp_q[$], act_q[$];
    int          error_cnt = 0, checks = 0, cyc = 0, slp_cnt = 0;
    wire  [10:0] mode = {dis, lane, cur, term, dcs, slp, nap1, nap2};
    // open drain: pull-up unless pulled low; host drives it only as a strap
    wire         sdo_line = sdo_oe ? 1'b0 : (ps ? sdo_strap : 1'b1);
    always #12.5 clk = ~clk;
    always @(negedge clk) tick <= ~tick;
    amc_host host (.sys_clk_i(clk), .sdo_line_i(sdo_line), .cs_n_o(cs_n), .sck_o(sck),
        .sdi_o(sdi));
    amc_config_port uut (.sys_clk_i(clk), .reset_i(rst), .program_select_i(ps),
        .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_line), .sample_tick_i(tick),
        .ch1_data_i(d1), .ch2_data_i(d2), .sdo_o(sdo_d), .sdo_oe_o(sdo_oe),
        .ch1_data_o(q1), .ch2_data_o(q2), .driver_disable_o(dis),
        .lane_count_select_o(lane), .driver_current_select_o(cur),
        .internal_termination_on_o(term), .duty_stabilizer_off_o(dcs), .sleep_o(slp),
        .ch1_nap_o(nap1), .ch2_nap_o(nap2), .ch1_ready_o(rdy1), .ch2_ready_o(rdy2));
    // scoreboard: oldest expectation against oldest observation
    always @(posedge clk) begin
        logic [31:0] e, a;
        cyc <= cyc + 1;
        if (slp) slp_cnt <= slp_cnt + 1;
        while (act_q.size() > 0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            a = act_q.pop_front();
            checks++;
            if (a !== e) begin
                error_cnt++;
                $display("BAD t=%0t exp=%h act=%h", $time, e, a);
            end
        end
        // run needs about 6700 cycles; a hang ends here
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic note(input logic [31:0] e, input logic [31:0] a);
        exp_q.push_back(e);
        act_q.push_back(a);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        host.xfer({1'b0, a, d}, 16, rd);
    endtask
    // read data bits on sdi are random: the port must ignore them
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] rd;
        host.xfer({1'b1, a, 8'($urandom)}, 16, rd);
        note({24'h0, e}, {24'h0, rd});
    endtask
    // offset binary to output form: sign flip, then lsb scramble
    function automatic logic [15:0] fmt(input logic [15:0] x, input logic [7:0] f);
        logic [15:0] y;
        y = f[5] ? x ^ 16'h8000 : x;
        if (f[6]) y[15:1] = y[15:1] ^ {15{y[0]}};
        return y;
    endfunction
    initial begin
        logic [7:0]  v, rd;
        logic [15:0] p;
        logic [7:0]  nap_tab [4];
        int          n;
        void'($urandom(65));
        nap_tab = '{8'h01, 8'h09, 8'h10, 8'h08};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // strap sweep; sleep only in the upper half so naps settle once
        for (int i = 0; i < 16; i++) begin
            host.strap({i[2], i[1], i[3]});
            sdo_strap = i[0];
            repeat (8) @(negedge clk);
            note({22'h0, 2'(i >> 1), i[0] ? AMC_CUR_1P75MA : AMC_CUR_3P5MA, 2'b0, {3{i[3]}}},
                {21'h0, mode});
        end
        host.strap(3'b100);
        ps = 1'b0;
        repeat (500) @(negedge clk);
        n = slp_cnt;
        wr(AMC_ADDR_RESET, 8'h80);
        repeat (10) @(negedge clk);
        note(AMC_SLEEP_PULSE_CYC, slp_cnt - n);
        for (int k = 0; k < 4; k++) begin
            v = 8'(k << 5) | (8'($urandom) & 8'h80);
            wr(AMC_ADDR_FORMAT, v);
            rdchk(AMC_ADDR_FORMAT, v);
            d1 = 16'($urandom);
            d2 = 16'($urandom);
            repeat (3) @(negedge clk);
            note({fmt(d1, v), fmt(d2, v)}, {q1, q2});
            note(32'(v[7]), 32'(dcs));
        end
        for (int k = 0; k < 4; k++) begin
            wr(AMC_ADDR_FORMAT, nap_tab[k]);
            v = nap_tab[k];
            repeat (4) @(negedge clk);
            note({29'h0, v[4], v[4] | v[0], v[4] | v[3]}, {29'h0, slp, nap1, nap2});
        end
        wr(AMC_ADDR_FORMAT, 8'h00);
        repeat (2000) @(negedge clk);
        note(32'h3, {30'h0, rdy1, rdy2});
        v = 8'($urandom);
        wr(AMC_ADDR_OUTMODE, v);
        rdchk(AMC_ADDR_OUTMODE, v);
        repeat (3) @(negedge clk);
        note({21'h0, v[3], v[1:0], v[7:5], v[4], 4'h0}, {21'h0, mode});
        p = 16'($urandom);
        wr(AMC_ADDR_PAT_HIGH, p[15:8]);
        wr(AMC_ADDR_PAT_LOW, p[7:0]);
        wr(AMC_ADDR_FORMAT, 8'h60);
        wr(AMC_ADDR_OUTMODE, 8'h04);
        repeat (3) @(negedge clk);
        note({p, p}, {q1, q2});
        host.xfer({1'b0, AMC_ADDR_PAT_LOW, 8'h5a}, 20, rd);
        host.xfer({1'b0, AMC_ADDR_PAT_LOW, 8'ha5}, 10, rd);
        rdchk(AMC_ADDR_PAT_LOW, 8'h5a);
        wr(7'h10, 8'hff);
        rdchk(7'h10, 8'h00);
        rdchk(AMC_ADDR_RESET, AMC_RESET_READ);
        wr(AMC_ADDR_RESET, 8'hff);
        rdchk(AMC_ADDR_FORMAT, AMC_REG_RESET_VAL);
        rdchk(AMC_ADDR_PAT_HIGH, AMC_REG_RESET_VAL);
        note(32'h0, {21'h0, mode});
        note({d1, d2}, {q1, q2});
        repeat (8) @(negedge clk);
        conclude();
    end
endmodule // tb_amc_config_port
